// ### core/etsc_capture.sv
// Event time stamp capture: free-running time and event counters, fine code capture and sample records.
// Assumes trigger pins are already slope/level qualified edges from comparators outside this block.
// Functional notes
// - Measure fine interval to next coarse pulse; here fine_code_i comes in from outside
// - Report five-bit unsigned fine code with time
// - Time counter increments every clock cycle
// - Output 32-bit time, 16-bit in short mode
// - Count every event, skip unstampable time
// - Increment event counter once per trigger
// - Stamp the instant a block is armed
// - Capture on arm then event, or arm alone
// - Start sample on start, stop on stop
// - Samples pair counts; arm samples lack count
// - Counters wrap to zero without stopping
// - Output 32-bit event count, 16-bit short
// - Extended mode adds event counts to output
`default_nettype none
`include "etsc_params.svh"
module etsc_capture (
   input  wire logic                      sys_clk_i,     // System clock, 200 MHz.
   input  wire logic                      nrst_i,        // Asynchronous reset, active low.
   input  wire logic                      start_trig_i,  // Start channel trigger level, asynchronous.
   input  wire logic                      stop_trig_i,   // Stop channel trigger level, asynchronous.
   input  wire logic [`ETSC_FINE_W-1:0]   fine_code_i,   // Interpolator code, sampled with the trigger.
   input  wire logic                      arm_i,         // Block arm request, asynchronous level.
   input  wire logic                      arm_stamp_en_i,// Stamp the block arm instant, asynchronous.
   input  wire logic                      arm_alone_i,   // Arm alone starts timing, asynchronous.
   input  wire logic                      short_mode_i,  // Short-word output, asynchronous.
   input  wire logic                      ext_mode_i,    // Extended records with counts, asynchronous.
   output logic                           smp_valid_o,   // One-cycle pulse, a record is presented.
   output logic [`ETSC_WORD_W-1:0]        smp_time_o,    // Coarse time count of the record.
   output logic [`ETSC_FINE_W-1:0]        smp_fine_o,    // Fine code of the record.
   output logic [`ETSC_WORD_W-1:0]        smp_event_o,   // Event count of the record.
   output logic                           smp_has_evt_o, // Record carries an event count.
   output logic [1:0]                     smp_kind_o,    // Record kind, see etsc_rec_t.
   output logic                           missed_o       // One-cycle pulse, an event went unstamped.
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   // Every asynchronous input except the reset passes two flops; only the second stage is read.
   localparam int NSYNC = 7;
   logic [NSYNC-1:0] sync1_q, sync2_q, sync_d;
   logic [NSYNC-1:0] async_in;
   logic [`ETSC_FINE_W-1:0] fine1_q, fine2_q;
   assign async_in = {start_trig_i, stop_trig_i, arm_i, arm_stamp_en_i, arm_alone_i, short_mode_i, ext_mode_i};

   // Next values of the synchroniser chain.
   always_comb begin
      sync_d = async_in;
   end

   // Two-stage chain, also carrying the interpolator code so it aligns with the trigger edge.
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
         fine1_q <= `ETSC_FINE_RST;
         fine2_q <= `ETSC_FINE_RST;
      end else begin
         sync1_q <= sync_d;
         sync2_q <= sync1_q;
         fine1_q <= fine_code_i;
         fine2_q <= fine1_q;
      end
   end

   // Named views of the synchronised levels.
   logic start_s, stop_s, arm_s, armst_s, armal_s, short_s, ext_s;
   assign {start_s, stop_s, arm_s, armst_s, armal_s, short_s, ext_s} = sync2_q;

   // ****************************************************************
   // Edge detection
   // ****************************************************************
   // Previous synchronised levels, so each trigger yields exactly one event.
   logic start_prev_q, stop_prev_q, arm_prev_q;
   logic start_prev_d, stop_prev_d, arm_prev_d;
   logic start_ev, stop_ev, arm_ev;

   // Rising edges of the qualified triggers.
   always_comb begin
      start_prev_d = start_s;
      stop_prev_d  = stop_s;
      arm_prev_d   = arm_s;
      start_ev     = start_s & ~start_prev_q;
      stop_ev      = stop_s & ~stop_prev_q;
      arm_ev       = arm_s & ~arm_prev_q;
   end

   // Edge history registers.
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         start_prev_q <= 1'b0;
         stop_prev_q  <= 1'b0;
         arm_prev_q   <= 1'b0;
      end else begin
         start_prev_q <= start_prev_d;
         stop_prev_q  <= stop_prev_d;
         arm_prev_q   <= arm_prev_d;
      end
   end

   // ****************************************************************
   // Free-running counters
   // ****************************************************************
   // Time counter in coarse ticks; event counter counts every trigger.
   logic [`ETSC_WORD_W-1:0] time_q, time_d, evt_q, evt_d;
   logic [1:0]              evt_inc;

   // Next counter values.
   always_comb begin
      time_d  = time_q + `ETSC_WORD_W'(`ETSC_TICKS_PER_CLK);
      evt_inc = {1'b0, start_ev} + {1'b0, stop_ev};
      evt_d   = evt_q + `ETSC_WORD_W'(evt_inc);
   end

   // Counter registers; they never stop, so the host corrects rollovers.
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         time_q <= `ETSC_CNT_RST;
         evt_q  <= `ETSC_CNT_RST;
      end else begin
         time_q <= time_d;
         evt_q  <= evt_d;
      end
   end

   // ****************************************************************
   // Capture state machine and record output
   // ****************************************************************
   // Waits for arm, then a start event, then a stop event. An arm alone can also start timing.
   etsc_pkg::etsc_state_t st_q, st_d;
   logic                      v_d, v_q, he_d, he_q, ms_d, ms_q;
   logic [`ETSC_WORD_W-1:0]   t_d, t_q, e_d, e_q;
   logic [`ETSC_FINE_W-1:0]   f_d, f_q;
   logic [1:0]                k_d, k_q;
   logic                      take;
   etsc_pkg::etsc_rec_t       kind;

   // Next state and record. Only one record per cycle can be issued; a second start or stop event in the
   // same cycle is counted but not stamped, and is flagged as missed unless it comes alone beside an arm record.
   always_comb begin
      st_d = st_q;
      take = 1'b0;
      kind = etsc_pkg::ETSC_REC_EVENT;
      ms_d = 1'b0;
      case (st_q)
         etsc_pkg::ETSC_IDLE: begin
            if (arm_ev) begin
               st_d = armal_s ? etsc_pkg::ETSC_WAIT_STOP : etsc_pkg::ETSC_WAIT_START;
               take = armst_s | armal_s;
               kind = etsc_pkg::ETSC_REC_ARM;
            end
         end
         etsc_pkg::ETSC_WAIT_START: begin
            if (start_ev) begin
               st_d = etsc_pkg::ETSC_WAIT_STOP;
               take = 1'b1;
               kind = etsc_pkg::ETSC_REC_START;
            end
         end
         etsc_pkg::ETSC_WAIT_STOP: begin
            if (stop_ev) begin
               st_d = etsc_pkg::ETSC_IDLE;
               take = 1'b1;
               kind = etsc_pkg::ETSC_REC_STOP;
            end
         end
         default: begin
            st_d = etsc_pkg::ETSC_IDLE;
         end
      endcase
      ms_d = ((start_ev | stop_ev) & ~take) | (start_ev & stop_ev);
      v_d  = take;
      t_d  = short_s ? {16'h0000, time_q[`ETSC_SHORT_W-1:0]} : time_q;
      f_d  = fine2_q;
      he_d = take & ext_s & (kind != etsc_pkg::ETSC_REC_ARM);
      e_d  = !he_d ? 32'h0000_0000 : (short_s ? {16'h0000, evt_q[`ETSC_SHORT_W-1:0]} : evt_q);
      k_d  = kind;
      if (!take) begin
         t_d = t_q;
         f_d = f_q;
         e_d = e_q;
         k_d = k_q;
         he_d = he_q;
      end
   end

   // Record registers feed the outputs directly.
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= etsc_pkg::ETSC_IDLE;
         v_q  <= 1'b0;
         ms_q <= 1'b0;
         he_q <= 1'b0;
         t_q  <= `ETSC_CNT_RST;
         e_q  <= `ETSC_CNT_RST;
         f_q  <= `ETSC_FINE_RST;
         k_q  <= 2'h0;
      end else begin
         st_q <= st_d;
         v_q  <= v_d;
         ms_q <= ms_d;
         he_q <= he_d;
         t_q  <= t_d;
         e_q  <= e_d;
         f_q  <= f_d;
         k_q  <= k_d;
      end
   end

   assign smp_valid_o   = v_q;
   assign smp_time_o    = t_q;
   assign smp_fine_o    = f_q;
   assign smp_event_o   = e_q;
   assign smp_has_evt_o = he_q;
   assign smp_kind_o    = k_q;
   assign missed_o      = ms_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // Every check runs on the system clock and is switched off while reset is low.
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   // Counter checks. The history values are still reset values on the first edge after
   // release, so each history check waits until reset was seen high one edge earlier.
   time_runs_a: assert property ($past(nrst_i) |->
      time_q == $past(time_q) + `ETSC_WORD_W'(`ETSC_TICKS_PER_CLK))
      else $error("time counter did not advance");
   evt_count_a: assert property ($past(nrst_i) |->
      evt_q == $past(evt_q) + `ETSC_WORD_W'($past(evt_inc)))
      else $error("event counter mismatch");

   // Arming and sample sequence checks.
   start_smp_a: assert property (st_q == etsc_pkg::ETSC_WAIT_START && start_ev |=>
      v_q && k_q == 2'(etsc_pkg::ETSC_REC_START))
      else $error("start sample missing");
   stop_smp_a: assert property (st_q == etsc_pkg::ETSC_WAIT_STOP && stop_ev |=>
      v_q && st_q == etsc_pkg::ETSC_IDLE)
      else $error("stop sample missing");
   arm_stamp_a: assert property (st_q == etsc_pkg::ETSC_IDLE && arm_ev && armst_s |=>
      v_q && !he_q)
      else $error("arm stamp missing or carries count");
   arm_alone_a: assert property (st_q == etsc_pkg::ETSC_IDLE && arm_ev && armal_s |=>
      v_q && st_q == etsc_pkg::ETSC_WAIT_STOP && k_q == 2'(etsc_pkg::ETSC_REC_ARM))
      else $error("arm alone did not stamp and skip the start wait");
   arm_ignore_a: assert property (st_q != etsc_pkg::ETSC_IDLE && arm_ev && !start_ev && !stop_ev |=>
      !v_q && st_q == $past(st_q))
      else $error("arm while busy changed the block");

   // Record content checks. Mode levels are taken at the capture edge, since they may move later.
   short_time_a: assert property (v_q && $past(short_s) |->
      t_q[31:16] == 16'h0000)
      else $error("short time word too wide");
   same_cycle_a: assert property (take |=>
      t_q == ($past(short_s) ? {16'h0000, $past(time_q[15:0])} : $past(time_q)))
      else $error("time not captured with record");
   fine_cap_a: assert property (take |=>
      f_q == $past(fine2_q))
      else $error("fine code not captured");
   evt_word_a: assert property (take && ext_s && kind != etsc_pkg::ETSC_REC_ARM |=>
      he_q && e_q == ($past(short_s) ? {16'h0000, $past(evt_q[15:0])} : $past(evt_q)))
      else $error("event word not captured with record");
   arm_no_cnt_a: assert property (v_q && k_q == 2'(etsc_pkg::ETSC_REC_ARM) |->
      !he_q && e_q == 32'h0000_0000)
      else $error("arm record carries a count");
   ext_cnt_a: assert property (v_q && he_q |->
      $past(ext_s))
      else $error("count without extended mode");
   no_count_a: assert property (v_q && !$past(ext_s) |->
      !he_q && e_q == 32'h0000_0000)
      else $error("count sent with extended mode off");

   // Missed event checks: a start or stop event in a cycle with no record, or both at once, raises the flag.
   missed_flag_a: assert property (start_ev && stop_ev |=>
      missed_o)
      else $error("missed event not flagged");
   missed_any_a: assert property ((start_ev || stop_ev) && !take |=>
      missed_o)
      else $error("unstamped event not flagged");

   // Main scenarios that the bench is expected to reach.
   cov_start_c: cover property (st_q == etsc_pkg::ETSC_WAIT_START ##1 v_q);
   cov_full_c:  cover property (st_q == etsc_pkg::ETSC_WAIT_STOP && stop_ev);
   cov_miss_c:  cover property (missed_o);
   cov_wrap_c:  cover property (time_q[15:0] < $past(time_q[15:0]));
   cov_pair_c:  cover property (start_ev && stop_ev);
endmodule
`default_nettype wire

// ### core/etsc_params.svh
// Constants for the event time stamp capture block: widths, timing figures and reset values.
// Assumes inclusion by bare name from the design file and the package.
`ifndef ETSC_PARAMS_SVH
`define ETSC_PARAMS_SVH

// ****************************************************************
// Widths
// ****************************************************************
// Full word width of time and event data.
`define ETSC_WORD_W      32
// Short-word width used when the short-word mode is selected.
`define ETSC_SHORT_W     16
// Width of the fine interpolator code.
`define ETSC_FINE_W      5

// ****************************************************************
// Timing figures
// ****************************************************************
// Coarse time resolution in picoseconds.
`define ETSC_COARSE_PS   2000
// Fine interpolator resolution in picoseconds.
`define ETSC_FINE_PS     200
// Clock period of this implementation in picoseconds.
`define ETSC_CLK_PS      5000
// Coarse ticks added to the time counter per clock cycle, at least one.
`define ETSC_TICKS_PER_CLK ((`ETSC_CLK_PS / `ETSC_COARSE_PS) < 1 ? 1 : (`ETSC_CLK_PS / `ETSC_COARSE_PS))

// ****************************************************************
// Reset values
// ****************************************************************
`define ETSC_CNT_RST     32'h0000_0000
`define ETSC_FINE_RST    5'h00

`endif

// ### core/etsc_pkg.sv
// Types shared by the event time stamp capture block.
// Assumes the parameter header sits on the include path.
`default_nettype none
`include "etsc_params.svh"
package etsc_pkg;
   // Kind of record presented on the sample output.
   typedef enum logic [1:0] {
      ETSC_REC_START,
      ETSC_REC_STOP,
      ETSC_REC_ARM,
      ETSC_REC_EVENT
   } etsc_rec_t;
   // Capture machine state.
   typedef enum logic [1:0] {
      ETSC_IDLE,
      ETSC_WAIT_START,
      ETSC_WAIT_STOP
   } etsc_state_t;
endpackage
`default_nettype wire

// ### tb/etsc_host_model.sv
// Host model: reads the sample stream and tallies records and unstamped events.
// Assumes it shares the single system clock and reset of the capture block.
`default_nettype none
module etsc_host_model (
   input  wire logic sys_clk_i,   // System clock.
   input  wire logic nrst_i,      // Reset, active low.
   input  wire logic smp_valid_i, // Record pulse.
   input  wire logic missed_i,    // Unstamped event pulse.
   output var  int   rec_cnt_o,   // Records read.
   output var  int   miss_cnt_o   // Unstamped events seen.
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // Tally
   // ****************************************************************
   // Both pulses stand one cycle, so each is read at the edge that sees it.
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rec_cnt_o  <= 0;
         miss_cnt_o <= 0;
      end else begin
         if (smp_valid_i === 1'b1) rec_cnt_o <= rec_cnt_o + 1;
         if (missed_i === 1'b1) miss_cnt_o <= miss_cnt_o + 1;
      end
   end
endmodule
`default_nettype wire

// ### tb/tb_event_time_stamp_capture.sv
// Self-checking bench: drives triggers and arming, predicts every record with a queue model.
// Assumes the capture block and the host model are compiled before this file.
`default_nettype none
module tb_event_time_stamp_capture;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [1:0] kind; logic has; logic [4:0] fine; int rise; int evd;} etsc_exp_t;
   logic        sys_clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        start_trig_i = 1'b0, stop_trig_i = 1'b0, arm_i = 1'b0;
   logic [4:0]  fine_code_i = 5'h00;
   logic        arm_stamp_en_i = 1'b0, arm_alone_i = 1'b0, short_mode_i = 1'b0, ext_mode_i = 1'b0;
   logic        smp_valid_o, smp_has_evt_o, missed_o;
   logic [31:0] smp_time_o, smp_event_o, prev_time, prev_evt, mask;
   logic [4:0]  smp_fine_o;
   logic [1:0]  smp_kind_o;
   etsc_exp_t   exp_q[$];
   int          fails = 0, checked = 0, cyc = 0, state = 0, misses = 0, recs = 0;
   int          evt_since = 0, prev_rise = 0, rec_cnt, miss_cnt;
   bit          have_t = 0, have_e = 0;
   // ****************************************************************
   // Clock, design and host
   // ****************************************************************
   always #2.5 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) cyc <= cyc + 1;
   etsc_capture DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .start_trig_i(start_trig_i),
      .stop_trig_i(stop_trig_i), .fine_code_i(fine_code_i), .arm_i(arm_i), .arm_stamp_en_i(arm_stamp_en_i),
      .arm_alone_i(arm_alone_i), .short_mode_i(short_mode_i), .ext_mode_i(ext_mode_i),
      .smp_valid_o(smp_valid_o), .smp_time_o(smp_time_o), .smp_fine_o(smp_fine_o), .smp_event_o(smp_event_o),
      .smp_has_evt_o(smp_has_evt_o), .smp_kind_o(smp_kind_o), .missed_o(missed_o));
   etsc_host_model host (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .smp_valid_i(smp_valid_o),
      .missed_i(missed_o), .rec_cnt_o(rec_cnt), .miss_cnt_o(miss_cnt));
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic finish_test();
      if (fails == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Modes settle for a few edges; chains restart because widths may differ.
   task automatic set_modes(input logic st, input logic al, input logic sh, input logic ex);
      @(posedge sys_clk_i);
      {arm_stamp_en_i, arm_alone_i, short_mode_i, ext_mode_i} <= {st, al, sh, ex};
      have_t = 0;
      have_e = 0;
      mask = sh ? 32'h0000FFFF : 32'hFFFFFFFF;
      repeat (4) @(posedge sys_clk_i);
   endtask
   // One rising edge on arm (0), start (1), stop (2) or start and stop together (3).
   // The record holds the count of events before its own edge, so events of that edge open the next span.
   task automatic pulse(input int which, input logic [4:0] f);
      etsc_exp_t e;
      bit        rec;
      int        n;
      @(posedge sys_clk_i);
      fine_code_i <= f;
      rec = 0;
      n = 0;
      e.rise = cyc;
      e.fine = f;
      e.has = ext_mode_i;
      e.kind = 2'(which == 0 ? 2 : which - 1);
      if (which == 0) begin
         arm_i <= 1'b1;
         e.has = 1'b0;
         if (state == 0) begin
            rec = arm_stamp_en_i | arm_alone_i;
            state = arm_alone_i ? 2 : 1;
         end
      end else begin
         if (which != 2) start_trig_i <= 1'b1;
         if (which != 1) stop_trig_i <= 1'b1;
         n = (which == 3) ? 2 : 1;
         if (which == 3) e.kind = (state == 1) ? 2'h0 : 2'h1;
         rec = (state == which) || (which == 3 && state != 0);
         if (!rec || which == 3) misses++;
         if (rec) state = (state == 1) ? 2 : 0;
      end
      e.evd = evt_since;
      if (rec && e.has) evt_since = n;
      else evt_since += n;
      if (rec) begin
         exp_q.push_back(e);
         recs++;
      end
      repeat (3) @(posedge sys_clk_i);
      {arm_i, start_trig_i, stop_trig_i} <= 3'h0;
      repeat (3) @(posedge sys_clk_i);
   endtask
   // ****************************************************************
   // Record monitor
   // ****************************************************************
   always @(posedge sys_clk_i) begin
      etsc_exp_t e;
      if (nrst_i === 1'b1 && smp_valid_o === 1'b1) begin
         if (exp_q.size() == 0) begin
            check_val("unexpected record", 32'h0, 32'h1);
         end else begin
            e = exp_q.pop_front();
            check_val("kind", 32'(e.kind), 32'(smp_kind_o));
            check_val("has_evt", 32'(e.has), 32'(smp_has_evt_o));
            check_val("fine", 32'(e.fine), 32'(smp_fine_o));
            if (have_t) check_val("time", (prev_time + 32'(2 * (e.rise - prev_rise))) & mask, smp_time_o);
            if (!e.has) check_val("event", 32'h0, smp_event_o);
            if (e.has && have_e) check_val("event", (prev_evt + 32'(e.evd)) & mask, smp_event_o);
            if (e.has) begin
               prev_evt = smp_event_o;
               have_e = 1;
            end
            prev_time = smp_time_o;
            prev_rise = e.rise;
            have_t = 1;
         end
      end
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      void'($urandom(32'h4E8A));
      mask = 32'hFFFFFFFF;
      repeat (20) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      set_modes(1, 0, 0, 1);
      pulse(0, 5'h1F); pulse(1, 5'h00); pulse(2, 5'h15);
      pulse(0, 5'h03); pulse(0, 5'h04); pulse(1, 5'h05); pulse(1, 5'h06); pulse(2, 5'h07); pulse(2, 5'h08);
      pulse(3, 5'h02);
      pulse(0, 5'h12);
      pulse(3, 5'h13);
      pulse(3, 5'h14);
      set_modes(1, 1, 0, 1);
      pulse(0, 5'h09); pulse(2, 5'h0A);
      set_modes(0, 0, 0, 0);
      pulse(0, 5'h0B); pulse(1, 5'h0C); pulse(2, 5'h0D);
      set_modes(1, 0, 1, 1);
      pulse(0, 5'h0E); pulse(1, 5'h10);
      repeat (33000) @(posedge sys_clk_i);
      pulse(2, 5'h11);
      set_modes(1, 0, 0, 1);
      for (int i = 0; i < 60; i++) begin
         pulse($urandom_range(0, 3), 5'($urandom));
         repeat ($urandom_range(0, 4)) @(posedge sys_clk_i);
      end
      for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge sys_clk_i);
      check_val("pending records", 32'h0, 32'(exp_q.size()));
      check_val("missed pulses", 32'(misses), 32'(miss_cnt));
      check_val("records read", 32'(recs), 32'(rec_cnt));
      finish_test();
   end
endmodule
`default_nettype wire
